/* File: rcb_defines.svh */
// Offsets, field positions, reset values and codes for the regulator config bank
`ifndef RCB_DEFINES_SVH
`define RCB_DEFINES_SVH
`define RCB_NUM_REG 4
`define RCB_ADDR_W 8
`define RCB_OFF_LN_TRANS 8'h95
`define RCB_OFF_LN_STATE 8'h96
`define RCB_OFF_LN_VOLT 8'h97
`define RCB_OFF_CARD_TRANS 8'h99
`define RCB_OFF_CARD_STATE 8'h9A
`define RCB_OFF_CARD_VOLT 8'h9B
`define RCB_OFF_GEN_TRANS 8'h9D
`define RCB_OFF_GEN_STATE 8'h9E
`define RCB_OFF_GEN_VOLT 8'h9F
`define RCB_OFF_USB_TRANS 8'hA1
`define RCB_OFF_USB_STATE 8'hA2
`define RCB_OFF_USB_VOLT 8'hA3
`define RCB_TRANS_SLEEP_LO 2
`define RCB_TRANS_RUN_HI 1
`define RCB_VOLT_WRS 7
`define RCB_VOLT_SEL_TOP 5
`define RCB_SLEEP_CMD_RST 2'h1
`define RCB_RUN_CMD_RST 2'h1
`define RCB_OFF_CMD_RST 2'h0
`define RCB_STATE_RST 2'h0
`define RCB_VOLT_SEL_DEFAULT 6'h10
`define RCB_CMD_OFF 2'h0
`define RCB_CMD_AUTO 2'h1
`define RCB_CMD_RSVD 2'h2
`define RCB_CMD_ON 2'h3
`endif

/* File: rcb_pkg.sv */
// Types for the regulator config bank
package rcb_pkg;
	typedef enum logic [1:0] {RCB_OUT_OFF, RCB_OUT_AUTO, RCB_OUT_ON} rcb_out_type;
	typedef struct packed {
		logic [1:0] sleep_cmd;
		logic [1:0] run_cmd;
		logic [1:0] req_state;
		logic wrs;
		logic [5:0] voltage_select;
	} rcb_chan_type;
endpackage

/* File: rcb_chan_if.sv */
// Per-regulator write strobes and field carrier between bank and channel
`timescale 1ns/10ps
interface rcb_chan_if;
	import rcb_pkg::*;
	logic wr_trans;
	logic wr_state;
	logic wr_volt;
	logic [7:0] wdata;
	logic force_off;
	logic volt_top_wr;
	rcb_chan_type fields;
	modport bank (output wr_trans, wr_state, wr_volt, wdata, force_off, volt_top_wr,
		input fields);
	modport chan (input wr_trans, wr_state, wr_volt, wdata, force_off, volt_top_wr,
		output fields);
endinterface

/* File: rcb_chan.sv */
// One regulator's transition, state and voltage fields with reset-domain handling
`timescale 1ns/10ps
module rcb_chan
	import rcb_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic warm_rst_n,
	input wire logic backup_rst_n,
	// Bank side
	rcb_chan_if.chan bus
);
`include "rcb_defines.svh"
	rcb_chan_type s_q;
	rcb_chan_type s_d;

	// Next-state: register writes, then hardware force, then reset domains
	always_comb
	begin
		s_d = s_q;
		if (bus.wr_trans)
		begin
			s_d.sleep_cmd[0] = bus.wdata[`RCB_TRANS_SLEEP_LO];
			s_d.run_cmd[1] = bus.wdata[`RCB_TRANS_RUN_HI];
		end
		if (bus.wr_state)
			s_d.req_state = bus.wdata[1:0];
		if (bus.force_off)
			s_d.req_state = `RCB_STATE_RST;
		if (bus.wr_volt)
		begin
			s_d.wrs = bus.wdata[`RCB_VOLT_WRS];
			s_d.voltage_select[4:0] = bus.wdata[4:0];
			s_d.voltage_select[5] = bus.volt_top_wr & bus.wdata[`RCB_VOLT_SEL_TOP];
		end
		if (!warm_rst_n)
		begin
			s_d.sleep_cmd = `RCB_SLEEP_CMD_RST;
			s_d.run_cmd = `RCB_RUN_CMD_RST;
			s_d.req_state = `RCB_STATE_RST;
			if (!s_q.wrs)
				s_d.voltage_select = `RCB_VOLT_SEL_DEFAULT;
		end
		if (!backup_rst_n)
		begin
			s_d.wrs = 1'b0;
			s_d.voltage_select = `RCB_VOLT_SEL_DEFAULT;
		end
		if (!bus.volt_top_wr)
			s_d.voltage_select[5] = 1'b0;
	end

	// State register
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			s_q.sleep_cmd <= `RCB_SLEEP_CMD_RST;
			s_q.run_cmd <= `RCB_RUN_CMD_RST;
			s_q.req_state <= `RCB_STATE_RST;
			s_q.wrs <= 1'b0;
			s_q.voltage_select <= `RCB_VOLT_SEL_DEFAULT;
		end
		else if (clk_en)
			s_q <= s_d;
	end

	assign bus.fields = s_q;

	AST_WRS_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && !warm_rst_n && backup_rst_n && s_q.wrs && !bus.wr_volt)
		|=> s_q.voltage_select == $past(s_q.voltage_select))
		else $error("voltage select lost across warm reset");
	AST_WRS_RELOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && !warm_rst_n && !s_q.wrs) |=> s_q.voltage_select == `RCB_VOLT_SEL_DEFAULT)
		else $error("voltage select not reloaded on warm reset");
	AST_RO_OFFBITS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && bus.wr_trans && warm_rst_n)
		|=> s_q.sleep_cmd[1] == $past(s_q.sleep_cmd[1]) && s_q.run_cmd[0] == $past(s_q.run_cmd[0]))
		else $error("read-only transition bit changed");
	AST_VOLT_TOP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!bus.volt_top_wr |-> s_q.voltage_select[5] == 1'b0)
		else $error("fixed voltage select bit not zero");
endmodule

/* File: rcb_bank.sv */
// Regulator configuration register bank: register port, decode and regulator controls
`timescale 1ns/10ps
module rcb_bank
	import rcb_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Reset domains
	input wire logic warm_rst_n,
	input wire logic backup_rst_n,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// System power state: 00 off, 01 sleep, 10 active
	input wire logic [1:0] sys_state,
	// Card and charger
	input wire logic card_extract,
	input wire logic card_reg_auto_shutoff,
	input wire logic chg_usb_take,
	input wire logic chg_usb_on,
	// Regulator controls, index 0 low-noise, 1 card, 2 general, 3 usb
	output logic [3:0] reg_enable,
	output logic [3:0] reg_auto_doze_run_mode,
	output logic [23:0] reg_voltage_select
);
`include "rcb_defines.svh"

	////////////////////////////////////////////////////////////////////////
	// Registered state
	typedef struct packed {
		logic [7:0] rdata;
		logic [3:0] en;
		logic [3:0] doze;
		logic [23:0] volt;
	} rcb_top_type;
	rcb_top_type t_q;
	rcb_top_type t_d;

	logic [7:0] trans_off [4];
	logic [7:0] state_off [4];
	logic [7:0] volt_off [4];
	assign trans_off[0] = `RCB_OFF_LN_TRANS;
	assign trans_off[1] = `RCB_OFF_CARD_TRANS;
	assign trans_off[2] = `RCB_OFF_GEN_TRANS;
	assign trans_off[3] = `RCB_OFF_USB_TRANS;
	assign state_off[0] = `RCB_OFF_LN_STATE;
	assign state_off[1] = `RCB_OFF_CARD_STATE;
	assign state_off[2] = `RCB_OFF_GEN_STATE;
	assign state_off[3] = `RCB_OFF_USB_STATE;
	assign volt_off[0] = `RCB_OFF_LN_VOLT;
	assign volt_off[1] = `RCB_OFF_CARD_VOLT;
	assign volt_off[2] = `RCB_OFF_GEN_VOLT;
	assign volt_off[3] = `RCB_OFF_USB_VOLT;

	rcb_chan_if ch [4] ();
	logic [7:0] rd_word [4];
	logic [3:0] hit_v;
	rcb_out_type outc [4];

	////////////////////////////////////////////////////////////////////////
	// Per-regulator decode, readback and command selection
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_ch
			rcb_chan u_chan (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.clk_en(clk_en),
				.warm_rst_n(warm_rst_n),
				.backup_rst_n(backup_rst_n),
				.bus(ch[g])
			);
			assign ch[g].wdata = reg_wdata;
			assign ch[g].wr_trans = reg_wr && reg_addr == trans_off[g];
			assign ch[g].wr_state = reg_wr && reg_addr == state_off[g];
			assign ch[g].wr_volt = reg_wr && reg_addr == volt_off[g];
			assign ch[g].volt_top_wr = (g == 0);
			assign ch[g].force_off = (g == 1) && card_extract && card_reg_auto_shutoff;

			// Readback with reserved bits as zero
			always_comb
			begin
				hit_v[g] = 1'b1;
				if (reg_addr == trans_off[g])
					rd_word[g] = {2'h0, `RCB_OFF_CMD_RST, ch[g].fields.sleep_cmd,
						ch[g].fields.run_cmd};
				else if (reg_addr == state_off[g])
					rd_word[g] = {6'h00, ch[g].fields.req_state};
				else if (reg_addr == volt_off[g])
					rd_word[g] = {ch[g].fields.wrs, 1'b0,
						ch[g].fields.voltage_select};
				else
				begin
					rd_word[g] = 8'h00;
					hit_v[g] = 1'b0;
				end
			end

			// Requested state picks the transition command to apply
			always_comb
			begin
				logic [1:0] cmd;
				cmd = `RCB_CMD_OFF;
				unique case (ch[g].fields.req_state)
					2'h1:
						unique case (sys_state)
							2'h0: cmd = `RCB_OFF_CMD_RST;
							2'h1: cmd = ch[g].fields.sleep_cmd;
							default: cmd = ch[g].fields.run_cmd;
						endcase
					2'h3: cmd = ch[g].fields.sleep_cmd;
					default: cmd = `RCB_CMD_OFF;
				endcase
				unique case (cmd)
					`RCB_CMD_AUTO: outc[g] = RCB_OUT_AUTO;
					`RCB_CMD_ON: outc[g] = RCB_OUT_ON;
					default: outc[g] = RCB_OUT_OFF;
				endcase
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Next value of the output registers
	always_comb
	begin
		t_d = t_q;
		t_d.rdata = reg_rd ? (rd_word[0] | rd_word[1] | rd_word[2] | rd_word[3]) : t_q.rdata;
		for (int i = 0; i < 4; i++)
		begin
			t_d.en[i] = outc[i] != RCB_OUT_OFF;
			t_d.doze[i] = outc[i] == RCB_OUT_AUTO;
		end
		if (chg_usb_take)
		begin
			t_d.en[3] = chg_usb_on;
			t_d.doze[3] = 1'b0;
		end
		t_d.volt = {ch[3].fields.voltage_select, ch[2].fields.voltage_select,
			ch[1].fields.voltage_select, ch[0].fields.voltage_select};
	end

	// Output registers
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			t_q <= '0;
		else if (clk_en)
			t_q <= t_d;
	end

	assign reg_rdata = t_q.rdata;
	assign reg_hit = |hit_v;
	assign reg_enable = t_q.en;
	assign reg_auto_doze_run_mode = t_q.doze;
	assign reg_voltage_select = t_q.volt;

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_CARD_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && card_extract && card_reg_auto_shutoff && warm_rst_n)
		|=> ch[1].fields.req_state == 2'h0)
		else $error("card regulator not forced off");
	AST_CHG_USB: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && chg_usb_take) |=> reg_enable[3] == $past(chg_usb_on))
		else $error("charger did not control usb regulator");
	AST_RSVD_STATE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && reg_rd && reg_addr == `RCB_OFF_GEN_STATE) |=> reg_rdata[7:2] == 6'h00)
		else $error("reserved state bits not zero");
	AST_STATE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(clk_en && !chg_usb_take && ch[3].fields.req_state[0] == 1'b0) |=> !reg_enable[3])
		else $error("off request left regulator on");
	AST_TRANS_RST: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> ch[0].fields.sleep_cmd == 2'h1 && ch[0].fields.run_cmd == 2'h1)
		else $error("transition reset value wrong");
endmodule

/* File: rcb_bench.sv */
// Self-checking bench for the regulator config bank
`timescale 1ns/10ps
`include "rcb_defines.svh"
`define CHK(nm, ex, got) \
	begin \
		checks_done++; \
		if ((got) !== (ex)) \
		begin \
			error_cnt++; \
			$display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
		end \
	end
module regulator_config_register_bank_bench;
	// Stimulus and observed outputs
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clk_en = 1'b1;
	logic warm_rst_n = 1'b1;
	logic backup_rst_n = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [1:0] sys_state = 2'h2;
	logic card_extract = 1'b0;
	logic card_reg_auto_shutoff = 1'b0;
	logic chg_usb_take = 1'b0;
	logic chg_usb_on = 1'b0;
	logic [7:0] reg_rdata;
	logic reg_hit;
	logic [3:0] reg_enable;
	logic [3:0] reg_auto_doze_run_mode;
	logic [23:0] reg_voltage_select;
	int error_cnt = 0;
	int checks_done = 0;
	// Offsets by regulator, then transition, state, voltage
	logic [7:0] offs [12] = '{`RCB_OFF_LN_TRANS, `RCB_OFF_LN_STATE, `RCB_OFF_LN_VOLT,
		`RCB_OFF_CARD_TRANS, `RCB_OFF_CARD_STATE, `RCB_OFF_CARD_VOLT,
		`RCB_OFF_GEN_TRANS, `RCB_OFF_GEN_STATE, `RCB_OFF_GEN_VOLT,
		`RCB_OFF_USB_TRANS, `RCB_OFF_USB_STATE, `RCB_OFF_USB_VOLT};
	logic [7:0] rst_val [3] = '{8'h05, 8'h00, 8'h10};
	// Decode cases: transition byte, state, system state, 0 off 1 auto 3 on
	logic [13:0] dec_tab [9] = '{{8'h02, 2'h1, 2'h2, 2'h3}, {8'h02, 2'h1, 2'h1, 2'h0},
		{8'h02, 2'h1, 2'h0, 2'h0}, {8'h04, 2'h1, 2'h2, 2'h1}, {8'h04, 2'h3, 2'h2, 2'h1},
		{8'h02, 2'h3, 2'h2, 2'h0}, {8'h02, 2'h2, 2'h2, 2'h0}, {8'h02, 2'h0, 2'h2, 2'h0},
		{8'h04, 2'h1, 2'h1, 2'h1}};

	rcb_bank u_rcb_bank (.ref_clk, .rst_n, .clk_en, .warm_rst_n, .backup_rst_n, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .sys_state, .card_extract,
		.card_reg_auto_shutoff, .chg_usb_take, .chg_usb_on, .reg_enable,
		.reg_auto_doze_run_mode, .reg_voltage_select);

	// 50 MHz clock
	always #10 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	// Register port cycles and closing report
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", ex, reg_rdata)
	endtask
	task automatic settle();
		repeat (3) @(posedge ref_clk);
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		for (int i = 0; i < 12; i++)
		begin
			rd(offs[i], rst_val[i % 3]);
			`CHK("reg_hit", 1'b1, reg_hit)
		end
		rd(8'h98, 8'h00);
		`CHK("reg_hit", 1'b0, reg_hit)
	endtask
	task automatic t_access();
		for (int i = 0; i < 12; i++)
		begin
			wr(offs[i], 8'hFF);
			rd(offs[i], (i % 3 == 0) ? 8'h07 : (i % 3 == 1) ? 8'h03 : (i == 2) ? 8'hBF : 8'h9F);
			wr(offs[i], 8'h00);
			rd(offs[i], (i % 3 == 0) ? 8'h01 : 8'h00);
		end
		wr(8'h98, 8'hFF);
		rd(8'h98, 8'h00);
	endtask
	task automatic t_decode();
		logic [13:0] e;
		for (int i = 0; i < 9; i++)
		begin
			e = dec_tab[i];
			wr(`RCB_OFF_GEN_TRANS, e[13:6]);
			sys_state <= e[3:2];
			wr(`RCB_OFF_GEN_STATE, {6'h00, e[5:4]});
			settle();
			`CHK("auto", e[1:0] == 2'h1, reg_auto_doze_run_mode[2])
			`CHK("enable", e[1:0] != 2'h0, reg_enable[2])
		end
	endtask
	task automatic t_warm();
		wr(`RCB_OFF_GEN_VOLT, 8'h0A);
		wr(`RCB_OFF_CARD_VOLT, 8'h8B);
		warm_rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		warm_rst_n <= 1'b1;
		rd(`RCB_OFF_GEN_VOLT, {2'h0, `RCB_VOLT_SEL_DEFAULT});
		rd(`RCB_OFF_CARD_VOLT, 8'h8B);
		`CHK("volt_gen", `RCB_VOLT_SEL_DEFAULT, reg_voltage_select[17:12])
		`CHK("volt_card", 6'h0B, reg_voltage_select[11:6])
		`CHK("volt_all", 24'h4102D0, reg_voltage_select)
		@(posedge ref_clk);
		backup_rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		backup_rst_n <= 1'b1;
		rd(`RCB_OFF_CARD_VOLT, {2'h0, `RCB_VOLT_SEL_DEFAULT});
	endtask
	task automatic t_card();
		wr(`RCB_OFF_CARD_STATE, 8'h01);
		card_extract <= 1'b1;
		settle();
		`CHK("card_auto", 1'b1, reg_auto_doze_run_mode[1])
		rd(`RCB_OFF_CARD_STATE, 8'h01);
		@(posedge ref_clk);
		card_reg_auto_shutoff <= 1'b1;
		rd(`RCB_OFF_CARD_STATE, 8'h00);
		settle();
		`CHK("card_auto", 1'b0, reg_auto_doze_run_mode[1])
		`CHK("card_en", 1'b0, reg_enable[1])
		@(posedge ref_clk);
		card_extract <= 1'b0;
	endtask
	task automatic t_charger();
		@(posedge ref_clk);
		chg_usb_take <= 1'b1;
		chg_usb_on <= 1'b1;
		settle();
		`CHK("usb_en", 1'b1, reg_enable[3])
		@(posedge ref_clk);
		chg_usb_on <= 1'b0;
		settle();
		`CHK("usb_en", 1'b0, reg_enable[3])
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence after a 12-cycle reset
	initial
	begin
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_access();
		t_decode();
		t_warm();
		t_card();
		t_charger();
		tally_and_finish();
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule
